// file: logic/gate_drive_pkg.sv
// Notes on behaviour
// - High side waits for bootstrap above turn-on.
// - Bootstrap below turn-off while high starts recharge.
// - Charge timeout raises bootstrap fault.
// - One drive mode for all gates.
// - Both currents zero gives switched transition.
// - Zero current stage is driven switched.
// - Turn-on: first current, timed, then second.
// - Fully on ends current drive, holds on.
// - Fully on from own drain-source comparator.
// - Turn-off: first current, timed, then second.
// - Fully off ends current drive, holds off.
// - Fully off from complement drain-source comparator.
// - Dead time between turn-off and complement turn-on.
// - Shared dead time is count times 50 ns.
// - Dead time never below 100 ns.
// - Passive pull-down only while output undriven.
package gate_drive_pkg;

  localparam int CLK_PERIOD_NS  = 25;
  localparam int DEAD_STEP_NS   = 50;
  localparam int DEAD_MIN_NS    = 100;
  localparam int STAGE_STEP_NS  = 100;
  localparam int CHARGE_TMO_NS  = 100000;
  localparam int DEAD_STEP_CYC  = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_MIN_COUNT = DEAD_MIN_NS / DEAD_STEP_NS;
  localparam int STAGE_STEP_CYC = (STAGE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHARGE_TMO_CYC = CHARGE_TMO_NS / CLK_PERIOD_NS;
  localparam logic [11:0] CHARGE_LAST = 12'(CHARGE_TMO_CYC - 1);

  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] RISE_OFF   = 8'h04;
  localparam logic [7:0] FALL_OFF   = 8'h08;
  localparam logic [7:0] DEAD_OFF   = 8'h0c;
  localparam logic [7:0] STATE_OFF  = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFF  = 8'h18;
  localparam logic [7:0] IRQ_EN_OFF   = 8'h1c;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_SLEW_BIT  = 1;
  localparam int CUR_FIRST_LSB  = 0;
  localparam int CUR_SECOND_LSB = 4;
  localparam int STAGE_LSB      = 8;

  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [11:0] SLEW_RST = 12'h000;
  localparam logic [5:0]  DEAD_RST = 6'h02;

  typedef enum logic [2:0] {S_IDLE, S_LOW, S_CHARGE, S_DEAD_H, S_HIGH, S_DEAD_L} phase_state_e;
  typedef enum logic [2:0] {G_OFF, G_RISE1, G_RISE2, G_ON, G_FALL1, G_FALL2} gate_state_e;

  function automatic logic [7:0] dead_load(input logic [5:0] count);
    logic [7:0] n;
    n = {2'h0, count};
    if (n < 8'(DEAD_MIN_COUNT))
    begin
      n = 8'(DEAD_MIN_COUNT);
    end
    return 8'(n * 8'(DEAD_STEP_CYC) - 8'h01);
  endfunction : dead_load

  function automatic logic [7:0] stage_load(input logic [3:0] t);
    if (t == 4'h0)
    begin
      return 8'h00;
    end
    return 8'({4'h0, t} * 8'(STAGE_STEP_CYC) - 8'h01);
  endfunction : stage_load

endpackage : gate_drive_pkg

// file: logic/timer_if.sv
`timescale 1ns/10ps
interface timer_if;
  logic       start;
  logic [7:0] load;
  logic       done;
  modport ctrl (output start, output load, input done);
  modport tmr  (input start, input load, output done);
endinterface : timer_if

// file: logic/cdc_sync.sv
`timescale 1ns/10ps
module cdc_sync #(parameter int W = 1)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (clk_en)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : cdc_sync

// file: logic/stage_timer.sv
`timescale 1ns/10ps
module stage_timer
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  timer_if.tmr      t
);
  logic [7:0] cnt;

  // Reload on every start so a new command never inherits old time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
    end
    else if (clk_en)
    begin
      if (t.start)
      begin
        cnt <= t.load;
      end
      else if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  assign t.done = (cnt == 8'h00) && !t.start;
endmodule : stage_timer

// file: logic/gate_drive_sequencer.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module gate_drive_sequencer
  import gate_drive_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  phase_cmd,
  input  wire logic [2:0]  hs_vds_low,
  input  wire logic [2:0]  ls_vds_low,
  input  wire logic [2:0]  boot_above_on,
  input  wire logic [2:0]  boot_below_off,
  output logic      [2:0]  high_side_gate_output,
  output logic      [2:0]  high_side_sink,
  output logic      [11:0] high_side_current,
  output logic      [2:0]  high_side_pulldown,
  output logic      [2:0]  low_side_gate_output,
  output logic      [2:0]  low_side_sink,
  output logic      [11:0] low_side_current,
  output logic      [2:0]  low_side_pulldown,
  output logic      [2:0]  boot_fault,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [1:0]  ctrl;
  logic [11:0] rise_cfg;
  logic [11:0] fall_cfg;
  logic [5:0]  dead_time_count;
  logic [2:0]  irq_status;
  logic [2:0]  irq_enable;
  wire  logic [2:0] fault_pulse;
  wire  logic [2:0] charging;
  wire  logic [5:0] src_w;
  wire  logic [5:0] snk_w;
  wire  logic [5:0] pd_w;
  wire  logic [3:0] cur_w [0:5];
  logic        wr_en;
  logic        bridge_en;
  logic        slew_mode;

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= IRQ_EN_OFF);
  endfunction : addr_ok

  assign pready    = clk_en;
  assign pslverr   = psel && penable && !addr_ok(paddr);
  assign wr_en     = psel && penable && pwrite && clk_en && addr_ok(paddr);
  assign bridge_en = ctrl[CTRL_EN_BIT];
  assign slew_mode = ctrl[CTRL_SLEW_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl            <= CTRL_RST;
      rise_cfg        <= SLEW_RST;
      fall_cfg        <= SLEW_RST;
      dead_time_count <= DEAD_RST;
      irq_enable      <= 3'h0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        CTRL_OFF:   ctrl <= pwdata[1:0];
        RISE_OFF:   rise_cfg <= pwdata[11:0];
        FALL_OFF:   fall_cfg <= pwdata[11:0];
        DEAD_OFF:   dead_time_count <= pwdata[5:0];
        IRQ_EN_OFF: irq_enable <= pwdata[2:0];
        default:    ;
      endcase
    end
  end

  // Read data is caught in the setup phase so it stands for the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (clk_en && psel && !penable)
    begin
      unique case (paddr)
        CTRL_OFF:     prdata <= {30'h0, ctrl};
        RISE_OFF:     prdata <= {20'h0, rise_cfg};
        FALL_OFF:     prdata <= {20'h0, fall_cfg};
        DEAD_OFF:     prdata <= {26'h0, dead_time_count};
        STATE_OFF:    prdata <= {23'h0, charging, src_w};
        IRQ_STAT_OFF: prdata <= {29'h0, irq_status};
        IRQ_EN_OFF:   prdata <= {29'h0, irq_enable};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // A fault in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 3'h0;
    end
    else if (clk_en)
    begin
      irq_status <= (irq_status & ~((wr_en && paddr == IRQ_CLR_OFF) ? pwdata[2:0] : 3'h0))
                    | fault_pulse;
    end
  end

  assign boot_fault = irq_status;
  assign irq        = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator inputs

  logic [2:0] hs_s;
  logic [2:0] ls_s;
  logic [2:0] bon_s;
  logic [2:0] boff_s;

  // Analog comparators are asynchronous to pclk
  cdc_sync #(.W(12)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       ({hs_vds_low, ls_vds_low, boot_above_on, boot_below_off}),
    .q       ({hs_s, ls_s, bon_s, boff_s})
  );

  logic       rise_slew;
  logic       fall_slew;
  logic [7:0] dead_ld;

  // Both currents zero means the whole transition is switched
  assign rise_slew = slew_mode && (rise_cfg[7:0] != 8'h00);
  assign fall_slew = slew_mode && (fall_cfg[7:0] != 8'h00);
  assign dead_ld   = dead_load(dead_time_count);

  wire logic [5:0] tgt;

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencers

  for (genvar p = 0; p < 3; p++)
  begin : phase
    phase_state_e ps;
    phase_state_e next_ps;
    logic [11:0]  cc;
    timer_if      dead_tmr ();

    stage_timer u_dead
    (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .t       (dead_tmr.tmr)
    );

    always_comb
    begin
      next_ps        = ps;
      dead_tmr.start = 1'b0;
      dead_tmr.load  = dead_ld;
      unique case (ps)
        S_IDLE:
          if (bridge_en)
          begin
            next_ps        = S_DEAD_L;
            dead_tmr.start = 1'b1;
          end
        S_LOW, S_CHARGE:
          if (!bridge_en)
            next_ps = S_IDLE;
          else if (!phase_cmd[p])
            next_ps = S_LOW;
          else if (bon_s[p])
          begin
            next_ps        = S_DEAD_H;
            dead_tmr.start = 1'b1;
          end
          else
            next_ps = S_CHARGE;
        S_DEAD_H:
          if (dead_tmr.done)
          begin
            if (bridge_en && phase_cmd[p] && bon_s[p])
              next_ps = S_HIGH;
            else if (!bridge_en)
              next_ps = S_IDLE;
            else
            begin
              next_ps        = S_DEAD_L;
              dead_tmr.start = 1'b1;
            end
          end
        S_HIGH:
          if (!bridge_en)
            next_ps = S_IDLE;
          else if (!phase_cmd[p] || boff_s[p])
          begin
            next_ps        = S_DEAD_L;
            dead_tmr.start = 1'b1;
          end
        S_DEAD_L:
          if (dead_tmr.done)
            next_ps = bridge_en ? S_LOW : S_IDLE;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ps <= S_IDLE;
      else if (clk_en)
        ps <= next_ps;
    end

    // Charge timeout keeps retrying; the fault repeats each period
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cc <= 12'h000;
      else if (clk_en)
      begin
        if (ps != S_CHARGE || cc == CHARGE_LAST)
          cc <= 12'h000;
        else
          cc <= cc + 12'h001;
      end
    end

    assign fault_pulse[p] = (ps == S_CHARGE) && (cc == CHARGE_LAST);
    assign charging[p]    = (ps == S_CHARGE);
    assign tgt[p]         = (ps == S_HIGH);
    assign tgt[p+3]       = (ps == S_LOW) || (ps == S_CHARGE);

    sequence s_dead_entry;
      (ps != S_DEAD_H) ##1 (ps == S_DEAD_H);
    endsequence

    property p_boot_gate;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      $rose(ps == S_HIGH) |-> $past(bon_s[p]);
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("high side without charge");

    property p_recharge;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      (ps == S_HIGH && bridge_en && phase_cmd[p] && boff_s[p]) |=> (ps == S_DEAD_L);
    endproperty
    a_recharge: assert property (p_recharge) else $error("no recharge on low boot");

    property p_fault;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      fault_pulse[p] |=> irq_status[p];
    endproperty
    a_fault: assert property (p_fault) else $error("boot fault not flagged");

    property p_dead_min;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      s_dead_entry |-> (ps == S_DEAD_H) [*4];
    endproperty
    a_dead_min: assert property (p_dead_min) else $error("dead time too short");

    property p_no_overlap;
      @(posedge pclk) disable iff (!presetn)
      !(src_w[p] && src_w[p+3]);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive sequencers, 0..2 high side, 3..5 low side

  for (genvar g = 0; g < 6; g++)
  begin : gate
    localparam int P = g % 3;
    gate_state_e gst;
    gate_state_e next_gst;
    logic        fon;
    logic        foff;
    logic        src_r;
    logic        snk_r;
    logic        pd_r;
    logic [3:0]  cur_r;
    timer_if     st ();

    stage_timer u_stage
    (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .t       (st.tmr)
    );

    assign fon  = (g < 3) ? hs_s[P] : ls_s[P];
    assign foff = (g < 3) ? ls_s[P] : hs_s[P];

    always_comb
    begin
      next_gst = gst;
      st.start = 1'b0;
      st.load  = 8'h00;
      unique case (gst)
        G_OFF, G_FALL1, G_FALL2:
          if (tgt[g])
          begin
            if (rise_slew)
            begin
              next_gst = G_RISE1;
              st.start = 1'b1;
              st.load  = stage_load(rise_cfg[STAGE_LSB +: 4]);
            end
            else
              next_gst = G_ON;
          end
          else if (gst == G_FALL1 && st.done)
            next_gst = G_FALL2;
          else if (gst == G_FALL2 && foff)
            next_gst = G_OFF;
        G_ON, G_RISE1, G_RISE2:
          if (!tgt[g])
          begin
            if (fall_slew)
            begin
              next_gst = G_FALL1;
              st.start = 1'b1;
              st.load  = stage_load(fall_cfg[STAGE_LSB +: 4]);
            end
            else
              next_gst = G_OFF;
          end
          else if (gst == G_RISE1 && st.done)
            next_gst = G_RISE2;
          else if (gst == G_RISE2 && fon)
            next_gst = G_ON;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        gst <= G_OFF;
      else if (clk_en)
        gst <= next_gst;
    end

    // Current code zero means full switched drive for that stage
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        src_r <= 1'b0;
        snk_r <= 1'b0;
        pd_r  <= 1'b1;
        cur_r <= 4'h0;
      end
      else if (clk_en)
      begin
        src_r <= (gst == G_RISE1) || (gst == G_RISE2) || (gst == G_ON);
        snk_r <= (gst == G_FALL1) || (gst == G_FALL2) || (gst == G_OFF && bridge_en);
        pd_r  <= (gst == G_OFF) && !bridge_en;
        unique case (gst)
          G_RISE1: cur_r <= rise_cfg[CUR_FIRST_LSB +: 4];
          G_RISE2: cur_r <= rise_cfg[CUR_SECOND_LSB +: 4];
          G_FALL1: cur_r <= fall_cfg[CUR_FIRST_LSB +: 4];
          G_FALL2: cur_r <= fall_cfg[CUR_SECOND_LSB +: 4];
          default: cur_r <= 4'h0;
        endcase
      end
    end

    assign src_w[g] = src_r;
    assign snk_w[g] = snk_r;
    assign pd_w[g]  = pd_r;
    assign cur_w[g] = cur_r;

    property p_switched;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      (!slew_mode && gst == G_OFF && tgt[g]) |=> (gst == G_ON);
    endproperty
    a_switched: assert property (p_switched) else $error("switched turn-on staged");

    property p_full_on;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      (gst == G_RISE2 && tgt[g] && fon) |=> (gst == G_ON) ##1 (src_r && cur_r == 4'h0);
    endproperty
    a_full_on: assert property (p_full_on) else $error("no hold after fully on");

    property p_full_off;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      (gst == G_FALL2 && !tgt[g] && foff) |=> (gst == G_OFF);
    endproperty
    a_full_off: assert property (p_full_off) else $error("no hold after fully off");

    property p_pulldown;
      @(posedge pclk) disable iff (!presetn || !clk_en)
      (gst == G_OFF && !bridge_en) |=> (pd_r && !src_r && !snk_r);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down while driven");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign high_side_gate_output = src_w[2:0];
  assign low_side_gate_output  = src_w[5:3];
  assign high_side_sink        = snk_w[2:0];
  assign low_side_sink         = snk_w[5:3];
  assign high_side_pulldown    = pd_w[2:0];
  assign low_side_pulldown     = pd_w[5:3];
  assign high_side_current     = {cur_w[2], cur_w[1], cur_w[0]};
  assign low_side_current      = {cur_w[5], cur_w[4], cur_w[3]};

endmodule : gate_drive_sequencer

// file: bench/bridge_model.sv
`timescale 1ns/10ps
module bridge_model #(parameter int LAG = 3)
(
  input  wire logic       pclk,
  input  wire logic [2:0] hs_on,
  input  wire logic [2:0] ls_on,
  input  wire logic [2:0] boot_ok,
  input  wire logic       freewheel_high,
  output logic      [2:0] hs_vds_low,
  output logic      [2:0] ls_vds_low,
  output logic      [2:0] boot_above_on,
  output logic      [2:0] boot_below_off
);
  logic [3*LAG-1:0] pipe = '0;
  logic [2:0]       node_now;

  ////////////////////////////////////////////////////////////////////////////////
  // Undriven node follows load current, picked by the bench
  assign node_now = hs_on | (~ls_on & {3{freewheel_high}});

  // Node swings only after the gate has had time to move
  always_ff @(posedge pclk)
  begin
    pipe <= {pipe[3*LAG-4:0], node_now};
  end

  assign hs_vds_low     = pipe[3*LAG-1 -: 3];
  assign ls_vds_low     = ~pipe[3*LAG-1 -: 3];
  assign boot_above_on  = boot_ok;
  assign boot_below_off = ~boot_ok;
endmodule : bridge_model

// file: bench/gate_drive_sequencer_tb_top.sv
`timescale 1ns/10ps
module gate_drive_sequencer_tb_top;
  import gate_drive_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  phase_cmd;
  logic [2:0]  hs_vds;
  logic [2:0]  ls_vds;
  logic [2:0]  b_on;
  logic [2:0]  b_off;
  logic [2:0]  hs_src;
  logic [2:0]  hs_snk;
  logic [11:0] hs_cur;
  logic [2:0]  hs_pd;
  logic [2:0]  ls_src;
  logic [2:0]  ls_snk;
  logic [11:0] ls_cur;
  logic [2:0]  ls_pd;
  logic [2:0]  boot_fault;
  logic        irq;
  logic [2:0]  boot_ok;
  logic        fw;
  logic [31:0] rdv;
  logic        err;
  logic        ce;
  int          n_fail;
  int          checked;
  int          cyc;

  gate_drive_sequencer u_gate_drive_sequencer (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_cmd(phase_cmd),
    .hs_vds_low(hs_vds), .ls_vds_low(ls_vds), .boot_above_on(b_on), .boot_below_off(b_off),
    .high_side_gate_output(hs_src), .high_side_sink(hs_snk), .high_side_current(hs_cur),
    .high_side_pulldown(hs_pd), .low_side_gate_output(ls_src), .low_side_sink(ls_snk),
    .low_side_current(ls_cur), .low_side_pulldown(ls_pd), .boot_fault(boot_fault), .irq(irq));

  bridge_model u_bridge_model (.pclk(pclk), .hs_on(hs_src), .ls_on(ls_src), .boot_ok(boot_ok),
    .freewheel_high(fw), .hs_vds_low(hs_vds), .ls_vds_low(ls_vds), .boot_above_on(b_on),
    .boot_below_off(b_off));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////////
  // Low clock enable must freeze every gate output
  task automatic t_freeze();
    ce        <= 1'b0;
    phase_cmd <= 3'h7;
    repeat (20) @(posedge pclk);
    chk("frozen_ls", 32'h7, 32'(ls_src));
    chk("frozen_hs", 32'h0, 32'(hs_src));
    ce        <= 1'b1;
    phase_cmd <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : t_freeze

  task automatic t_dead(input logic [5:0] cnt_set);
    int ex;
    int gap;
    apb(1'b1, DEAD_OFF, {26'h0, cnt_set});
    ex = ((cnt_set < 6'(DEAD_MIN_COUNT)) ? DEAD_MIN_COUNT : int'(cnt_set)) * DEAD_STEP_CYC;
    phase_cmd <= 3'h7;
    for (int n = 0; n < 100 && ls_src[0] !== 1'b0; n++)
      @(posedge pclk);
    for (gap = 0; gap < 300 && hs_src[0] !== 1'b1; gap++)
      @(posedge pclk);
    chk("dead_min", 32'h1, 32'(gap >= ex));
    chk("dead_max", 32'h1, 32'(gap <= ex + 3));
    @(posedge pclk);
    chk("all_high", 32'h7, 32'(hs_src));
    phase_cmd <= 3'h0;
    repeat (150) @(posedge pclk);
  endtask : t_dead

  // One staged transition of the high side of phase 0
  task automatic t_slew(input logic rise, input logic [11:0] cfg);
    int n1;
    apb(1'b1, rise ? RISE_OFF : FALL_OFF, {20'h0, cfg});
    apb(1'b1, rise ? FALL_OFF : RISE_OFF, 32'h0);
    // Freewheel keeps the node high until the low side conducts
    fw        <= !rise;
    phase_cmd <= {2'h0, ~rise};
    repeat (120) @(posedge pclk);
    phase_cmd <= {2'h0, rise};
    for (int n = 0; n < 100 && hs_cur[3:0] !== cfg[3:0]; n++)
      @(posedge pclk);
    for (n1 = 0; n1 < 200 && hs_cur[3:0] === cfg[3:0]; n1++)
      @(posedge pclk);
    chk("stage_len", 32'(cfg[11:8]) * STAGE_STEP_CYC, 32'(n1));
    chk("second_cur", 32'(cfg[7:4]), 32'(hs_cur[3:0]));
    for (int n = 0; n < 60 && hs_cur[3:0] !== 4'h0; n++)
      @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("hold_cur", 32'h0, 32'(hs_cur[3:0]));
    chk("hold_gate", 32'(rise), 32'(hs_src[0]));
    chk("hold_sink", 32'(!rise), 32'(hs_snk[0]));
  endtask : t_slew

  task automatic t_switched();
    apb(1'b1, RISE_OFF, 32'h0);
    phase_cmd <= 3'h1;
    repeat (60)
    begin
      @(posedge pclk);
      chk("sw_cur", 32'h0, 32'(hs_cur));
    end
    chk("sw_gate", 32'h1, 32'(hs_src[0]));
    phase_cmd <= 3'h0;
    repeat (60) @(posedge pclk);
  endtask : t_switched

  task automatic t_boot();
    // Let the low bootstrap pass the synchroniser before asking for high
    boot_ok   <= 3'h6;
    repeat (4) @(posedge pclk);
    phase_cmd <= 3'h1;
    repeat (60) @(posedge pclk);
    chk("wait_boot_hs", 32'h0, 32'(hs_src[0]));
    chk("charge_ls", 32'h1, 32'(ls_src[0]));
    boot_ok <= 3'h7;
    repeat (80) @(posedge pclk);
    chk("boot_ok_hs", 32'h1, 32'(hs_src[0]));
    boot_ok <= 3'h6;
    repeat (80) @(posedge pclk);
    chk("recharge_ls", 32'h1, 32'(ls_src[0]));
    apb(1'b1, IRQ_EN_OFF, 32'h1);
    for (int n = 0; n < 4200 && boot_fault[0] !== 1'b1; n++)
      @(posedge pclk);
    chk("fault", 32'h1, 32'(boot_fault));
    chk("irq_on", 32'h1, 32'(irq));
    boot_ok   <= 3'h7;
    phase_cmd <= 3'h0;
    apb(1'b1, IRQ_EN_OFF, 32'h0);
    @(posedge pclk);
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk("stat", 32'h1, rdv);
    apb(1'b1, IRQ_CLR_OFF, 32'h1);
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk("stat_clr", 32'h0, rdv);
  endtask : t_boot

  ////////////////////////////////////////////////////////////////////////////////
  // Shoot-through watch on every edge
  always @(posedge pclk)
  begin
    cyc++;
    if (presetn === 1'b1 && (hs_src & ls_src) !== 3'h0)
    begin
      n_fail++;
      $display("[ERR] both_on expected 0 seen %h", hs_src & ls_src);
    end
    if (cyc == 20000)
    begin
      n_fail++;
      $display("[ERR] timeout expected done seen hang");
      conclude();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    phase_cmd = 3'h0;
    boot_ok = 3'h7;
    fw = 1'b0;
    ce = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("pd_hs", 32'h7, 32'(hs_pd));
    chk("pd_ls", 32'h7, 32'(ls_pd));
    apb(1'b0, DEAD_OFF, 32'h0);
    chk("dead_rst", 32'(DEAD_RST), rdv);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'b1, CTRL_OFF, 32'h1);
    repeat (40) @(posedge pclk);
    chk("pd_driven", 32'h0, 32'(hs_pd | ls_pd));
    t_freeze();
    t_dead(6'h00);
    t_dead(6'h01);
    t_dead(6'h02);
    t_dead(6'h18);
    t_boot();
    t_switched();
    apb(1'b1, CTRL_OFF, 32'h3);
    t_switched();
    t_slew(1'b1, 12'h295);
    t_slew(1'b1, 12'h305);
    t_slew(1'b0, 12'h163);
    conclude();
  end
endmodule : gate_drive_sequencer_tb_top
